// *** dv/sbl_host_model.sv ***
// host at the far end of the boot link: zero byte, id capture, load bytes
`default_nettype none
module sbl_host_model #(
  parameter int BIT_CLKS = 64 // host bit length in device clocks
) (
  input wire logic clk_in,
  input wire logic go_in, // start the exchange
  input wire logic dev_txd_in, // device transmit line
  output logic host_txd_out, // device receive line, idle high
  output logic [7:0] id_out, // captured identification byte
  output logic done_out // all bytes sent
);
  timeunit 1ns;
  timeprecision 1ps;
  // one 8n1 character, start bit then lsb first
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_txd_out <= fr[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask
  initial begin
    host_txd_out = 1'b1;
    id_out = 8'h00;
    done_out = 1'b0;
    wait (go_in === 1'b1);
    @(posedge clk_in);
    // zero byte: start and eight data bits low; the answer may begin in our stop bit
    host_txd_out <= 1'b0;
    repeat (9 * BIT_CLKS) @(posedge clk_in);
    host_txd_out <= 1'b1;
    // poll for the start bit, then sample mid-bit
    while (dev_txd_in !== 1'b0) @(posedge clk_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_in);
      id_out[i] = dev_txd_in;
    end
    // let the stop bit pass fully, receiver opens only afterwards
    repeat (2 * BIT_CLKS) @(posedge clk_in);
    // one byte beyond the load count, which must be ignored
    for (int i = 0; i < 33; i++) send_byte(8'(i * 7 + 33));
    done_out = 1'b1;
  end
endmodule
`default_nettype wire

// *** dv/sbl_loader_properties.sv ***
// checker for the bootstrap loader: presets, fetch redirect, load and branch
`default_nettype none
module sbl_loader_properties (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic soft_rst_in,
  input wire logic flash_seg1_in,
  input wire logic [23:0] fetch_addr_in,
  input wire logic fetch_is_code_in,
  input wire logic serial_transmit_line_out,
  input wire logic transmit_pin_direction_out,
  input wire logic boot_loader_mode_out,
  input wire logic watchdog_disable_out,
  input wire logic use_external_access_out,
  input wire logic boot_rom_sel_out,
  input wire logic user_flash_sel_out,
  input wire logic [15:0] context_pointer_out,
  input wire logic [15:0] stack_pointer_out,
  input wire logic [15:0] stack_underflow_limit_out,
  input wire logic [15:0] stack_overflow_limit_out,
  input wire logic [15:0] serial_control_reg_out,
  input wire logic [15:0] system_config_reg_out,
  input wire logic ram_we_out,
  input wire logic [23:0] ram_addr_out,
  input wire logic jump_out,
  input wire logic [23:0] jump_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // access falls in the flash window, which moves with the segment mapping
  wire logic in_win;
  assign in_win = flash_seg1_in ? (fetch_addr_in >= sbl_pkg::FLASH_BASE_SEG1 &&
                  fetch_addr_in <= sbl_pkg::FLASH_TOP_SEG1) :
                  (fetch_addr_in <= sbl_pkg::FLASH_TOP_SEG0);
  a_watchdog_off: assert property (watchdog_disable_out == boot_loader_mode_out)
    else $error("watchdog disable does not follow loader mode");
  a_stack_presets: assert property ($rose(boot_loader_mode_out) |=>
    context_pointer_out == 16'hfa00 && stack_pointer_out == 16'hfa40 &&
    stack_underflow_limit_out == 16'hfa40 && serial_control_reg_out == 16'h8011)
    else $error("pointer or serial control preset wrong");
  a_config_presets: assert property ($rose(boot_loader_mode_out) |=>
    system_config_reg_out == 16'h0e00 && stack_overflow_limit_out == 16'hfa0c)
    else $error("config or overflow preset wrong");
  a_tx_idle_high: assert property (!transmit_pin_direction_out |-> serial_transmit_line_out)
    else $error("transmit line low before direction set");
  a_ext_pin_ignored: assert property (boot_loader_mode_out |-> !use_external_access_out)
    else $error("external access honoured in loader mode");
  a_code_to_rom: assert property (boot_loader_mode_out && fetch_is_code_in && in_win
    |-> boot_rom_sel_out && !user_flash_sel_out) else $error("code fetch not redirected");
  a_data_to_flash: assert property (boot_loader_mode_out && !fetch_is_code_in && in_win
    |-> user_flash_sel_out && !boot_rom_sel_out) else $error("data read not from user flash");
  a_ram_in_range: assert property (ram_we_out |-> transmit_pin_direction_out &&
    ram_addr_out >= sbl_pkg::LOAD_FIRST && ram_addr_out <= sbl_pkg::LOAD_LAST)
    else $error("load write outside load area");
  a_jump_after_last: assert property (ram_we_out && ram_addr_out == sbl_pkg::LOAD_LAST
    |-> ##[1:4] (jump_out && jump_addr_out == 24'h00fa40)) else $error("branch missing");
  a_mode_holds: assert property (boot_loader_mode_out && !soft_rst_in |=> boot_loader_mode_out)
    else $error("loader mode dropped without reset");
  a_soft_exit: assert property (soft_rst_in && ce_in |=> !boot_loader_mode_out)
    else $error("soft reset kept loader mode");
  c_mode_entry: cover property ($rose(boot_loader_mode_out));
  c_branch: cover property (jump_out);
  c_seg1_redirect: cover property (boot_rom_sel_out && flash_seg1_in);
endmodule
bind sbl_loader sbl_loader_properties u_props (.mclk_in, .rst_b_in, .ce_in, .soft_rst_in,
  .flash_seg1_in, .fetch_addr_in, .fetch_is_code_in, .serial_transmit_line_out,
  .transmit_pin_direction_out, .boot_loader_mode_out, .watchdog_disable_out,
  .use_external_access_out, .boot_rom_sel_out, .user_flash_sel_out, .context_pointer_out,
  .stack_pointer_out, .stack_underflow_limit_out, .stack_overflow_limit_out,
  .serial_control_reg_out, .system_config_reg_out, .ram_we_out, .ram_addr_out, .jump_out,
  .jump_addr_out);
`default_nettype wire

// *** dv/tb_top.sv ***
// top-level bench: boot exchange, presets, fetch redirect, mode exit
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_VAL = 8'h3b; // arbitrary identification value
  logic mclk_in, rst_b_in, ce_in, soft_rst_in, boot_select_pin_in, external_access_pin_in;
  logic flash_seg1_in, serial_receive_line_in, fetch_is_code_in, host_go, host_done;
  logic [23:0] fetch_addr_in, ram_addr_out, jump_addr_out;
  logic serial_transmit_line_out, transmit_pin_direction_out, boot_loader_mode_out;
  logic watchdog_disable_out, use_external_access_out, boot_rom_sel_out, user_flash_sel_out;
  logic ram_we_out, jump_out;
  logic [7:0] ram_wdata_out, host_id;
  logic [15:0] context_pointer_out, stack_pointer_out, stack_underflow_limit_out;
  logic [15:0] stack_overflow_limit_out, serial_control_reg_out, system_config_reg_out;
  logic [15:0] baud_reload_value_out;
  int err_count = 0;
  int checked = 0;
  int wr_n = 0; // load writes seen
  int jumps = 0; // branch pulses seen
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %0h expected %0h", $time, (a), (b)); end end
  initial mclk_in = 1'b0;
  always #5 mclk_in = ~mclk_in;
  sbl_loader #(.ID_BYTE(ID_VAL)) DUT (
    .mclk_in, .rst_b_in, .ce_in, .soft_rst_in, .boot_select_pin_in, .external_access_pin_in,
    .flash_seg1_in, .serial_receive_line_in, .fetch_addr_in, .fetch_is_code_in,
    .serial_transmit_line_out, .transmit_pin_direction_out, .boot_loader_mode_out,
    .watchdog_disable_out, .use_external_access_out, .boot_rom_sel_out, .user_flash_sel_out,
    .context_pointer_out, .stack_pointer_out, .stack_underflow_limit_out,
    .stack_overflow_limit_out, .serial_control_reg_out, .system_config_reg_out,
    .baud_reload_value_out, .ram_we_out, .ram_addr_out, .ram_wdata_out, .jump_out,
    .jump_addr_out);
  // 64 clocks a bit: zero byte counts 144, reload 1, device bit 64 clocks
  sbl_host_model #(.BIT_CLKS(64)) u_host (.clk_in(mclk_in), .go_in(host_go),
    .dev_txd_in(serial_transmit_line_out), .host_txd_out(serial_receive_line_in),
    .id_out(host_id), .done_out(host_done));
  // same byte pattern the host sends
  function automatic logic [7:0] load_byte(input int i);
    return 8'(i * 7 + 33);
  endfunction
  // watch load writes and the branch as they happen
  always @(posedge mclk_in) begin
    if (ram_we_out === 1'b1) begin
      `CHK(ram_addr_out, 24'h00fa40 + 24'(wr_n))
      `CHK(ram_wdata_out, load_byte(wr_n))
      wr_n++;
    end
    if (jump_out === 1'b1) begin
      `CHK(jump_addr_out, 24'h00fa40)
      `CHK(wr_n, 32)
      jumps++;
    end
  end
  // drive one access and compare {boot rom, user flash}
  task automatic fetch(input logic seg1, input logic [23:0] a, input logic code,
                       input logic [1:0] exp);
    @(posedge mclk_in);
    flash_seg1_in <= seg1;
    fetch_addr_in <= a;
    fetch_is_code_in <= code;
    @(negedge mclk_in);
    `CHK({boot_rom_sel_out, user_flash_sel_out}, exp)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst_b_in = 1'b0;
    ce_in = 1'b1;
    soft_rst_in = 1'b0;
    boot_select_pin_in = 1'b0;
    external_access_pin_in = 1'b1;
    flash_seg1_in = 1'b0;
    fetch_addr_in = 24'h000000;
    fetch_is_code_in = 1'b0;
    host_go = 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
    `CHK(boot_loader_mode_out, 1'b1)
    `CHK(watchdog_disable_out, 1'b1)
    `CHK({context_pointer_out, stack_pointer_out}, 32'hfa00_fa40)
    `CHK({stack_underflow_limit_out, serial_control_reg_out}, 32'hfa40_8011)
    `CHK({system_config_reg_out, stack_overflow_limit_out}, 32'h0e00_fa0c)
    `CHK(serial_transmit_line_out, 1'b1)
    `CHK(use_external_access_out, 1'b0)
    $display("test presets done");
    fetch(1'b0, 24'h000000, 1'b1, 2'b10);
    fetch(1'b0, 24'h007fff, 1'b1, 2'b10);
    fetch(1'b0, 24'h007fff, 1'b0, 2'b01);
    fetch(1'b0, 24'h008000, 1'b1, 2'b00);
    fetch(1'b1, 24'h017fff, 1'b1, 2'b10);
    fetch(1'b1, 24'h010000, 1'b0, 2'b01);
    fetch(1'b1, 24'h000100, 1'b1, 2'b00);
    $display("test fetch redirect done");
    host_go <= 1'b1;
    for (int i = 0; i < 40000 && host_done !== 1'b1; i++) @(posedge mclk_in);
    `CHK(host_done, 1'b1)
    repeat (700) @(posedge mclk_in);
    `CHK(host_id, ID_VAL)
    `CHK(baud_reload_value_out, 16'h0001)
    `CHK(transmit_pin_direction_out, 1'b1)
    `CHK(wr_n, 32)
    `CHK(jumps, 1)
    `CHK({boot_loader_mode_out, watchdog_disable_out}, 2'b11)
    $display("test boot exchange done");
    // a soft reset seen while the clock enable is low must be lost
    ce_in <= 1'b0;
    soft_rst_in <= 1'b1;
    @(posedge mclk_in);
    soft_rst_in <= 1'b0;
    @(posedge mclk_in);
    ce_in <= 1'b1;
    `CHK(boot_loader_mode_out, 1'b1)
    soft_rst_in <= 1'b1;
    @(posedge mclk_in);
    soft_rst_in <= 1'b0;
    @(negedge mclk_in);
    `CHK({boot_loader_mode_out, use_external_access_out}, 2'b01)
    @(posedge mclk_in);
    boot_select_pin_in <= 1'b1;
    rst_b_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
    `CHK(boot_loader_mode_out, 1'b0)
    `CHK(jump_addr_out, 24'h000000)
    fetch(1'b0, 24'h000100, 1'b1, 2'b01);
    $display("test mode exit done");
    complete_run();
  end
  // hang guard: the exchange needs about 23000 cycles
  initial begin
    repeat (60000) @(posedge mclk_in);
    err_count++;
    complete_run();
  end
  `undef CHK
endmodule
`default_nettype wire

// *** src/sbl_loader.sv ***
// serial bootstrap loader: mode select, baud measurement, id byte, 32-byte load, fetch redirect
`default_nettype none
// Function
// - low boot-select at reset end enters loader
// - watch receive line for host zero byte
// - derive baud factor, program channel, enable transmit
// - send identification byte at derived rate
// - watchdog disabled in loader mode
// - preset context, stack, underflow, serial control
// - preset system config, overflow limit, transmit pin
// - never execute from internal flash in loader
// - after id byte enable receiver, take 32
// - store bytes at FA40h through FA5Fh
// - branch to FA40h after last byte
// - stay in loader mode after the jump
// - ignore external-access pin in loader mode
// - code fetches in flash window go boot rom
// - data reads in flash window go user flash
// - boot rom window follows flash segment mapping
// - leave loader on soft reset or high pin
// - reload = (timer count - 36) / 72
module sbl_loader #(
  parameter logic [7:0] ID_BYTE = 8'h5a, // identification value, arbitrary
  parameter int LOAD_COUNT = sbl_pkg::LOAD_BYTES
) (
  input wire logic mclk_in,
  input wire logic rst_b_in, // hardware reset
  input wire logic ce_in, // clock enable, freezes all state
  input wire logic soft_rst_in, // one-cycle software reset request
  input wire logic boot_select_pin_in, // sampled at reset release
  input wire logic external_access_pin_in, // level of the external-access pin
  input wire logic flash_seg1_in, // internal flash mapped to segment 1
  input wire logic serial_receive_line_in,
  input wire logic [23:0] fetch_addr_in, // cpu access address
  input wire logic fetch_is_code_in, // access is a code fetch
  output logic serial_transmit_line_out,
  output logic transmit_pin_direction_out, // 1 = output
  output logic boot_loader_mode_out,
  output logic watchdog_disable_out,
  output logic use_external_access_out, // memory config may honour the pin
  output logic boot_rom_sel_out, // access served by boot rom
  output logic user_flash_sel_out, // access served by user flash
  output logic [15:0] context_pointer_out,
  output logic [15:0] stack_pointer_out,
  output logic [15:0] stack_underflow_limit_out,
  output logic [15:0] stack_overflow_limit_out,
  output logic [15:0] serial_control_reg_out,
  output logic [15:0] system_config_reg_out,
  output logic [15:0] baud_reload_value_out,
  output logic ram_we_out, // one-cycle internal ram byte write
  output logic [23:0] ram_addr_out,
  output logic [7:0] ram_wdata_out,
  output logic jump_out, // one-cycle branch request
  output logic [23:0] jump_addr_out
);
  // mode flag and startup sample
  logic mode_ff;
  logic sampled_ff; // set once the first enabled edge after release is seen
  sbl_pkg::sbl_state_t state_ff;
  sbl_pkg::sbl_state_t nxt_state;
  logic [15:0] meas_ff; // measurement timer
  logic [1:0] pre_ff; // measurement timer prescaler
  logic [15:0] quot_ff; // division result
  logic [15:0] rem_ff; // division remainder under subtraction
  logic [5:0] cnt_ff; // received byte count
  logic [15:0] reload_ff;
  logic [15:0] sys_ff;
  logic [15:0] ctx_ff, stk_ff, sun_ff, sov_ff, scon_ff;
  logic tdir_ff;
  logic tx_go_ff;
  logic we_ff;
  logic [23:0] waddr_ff;
  logic [7:0] wdata_ff;
  logic jump_ff;
  wire tx_busy;
  wire txd_ch;
  wire rx_valid;
  wire [7:0] rx_data;

  // serial channel, receiver only live while loading or after the jump
  wire rx_enable = (state_ff == sbl_pkg::SBL_LOAD) || (state_ff == sbl_pkg::SBL_RUN);
  sbl_uart #(.BIT_TICKS(sbl_pkg::BIT_TICKS)) u_chan (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .reload_in(reload_ff),
    .rx_en_in(rx_enable),
    .rxd_in(serial_receive_line_in),
    .tx_go_in(tx_go_ff),
    .tx_data_in(ID_BYTE),
    .tx_busy_out(tx_busy),
    .txd_out(txd_ch),
    .rx_valid_out(rx_valid),
    .rx_data_out(rx_data)
  );

  // measurement done when the line returns high after the zero byte
  wire line_hi = serial_receive_line_in;
  wire div_more = (rem_ff >= sbl_pkg::MEAS_DIVISOR);
  wire last_byte = rx_valid && (cnt_ff == 6'(LOAD_COUNT - 1));

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sbl_pkg::SBL_IDLE: nxt_state = mode_ff ? sbl_pkg::SBL_WAIT_START : sbl_pkg::SBL_IDLE;
      sbl_pkg::SBL_WAIT_START: if (!line_hi) nxt_state = sbl_pkg::SBL_MEASURE;
      sbl_pkg::SBL_MEASURE: if (line_hi) nxt_state = sbl_pkg::SBL_DIVIDE;
      sbl_pkg::SBL_DIVIDE: if (!div_more) nxt_state = sbl_pkg::SBL_SEND_ID;
      sbl_pkg::SBL_SEND_ID: nxt_state = sbl_pkg::SBL_WAIT_ID;
      sbl_pkg::SBL_WAIT_ID: if (!tx_busy && !tx_go_ff) nxt_state = sbl_pkg::SBL_LOAD;
      sbl_pkg::SBL_LOAD: if (last_byte) nxt_state = sbl_pkg::SBL_JUMP;
      sbl_pkg::SBL_JUMP: nxt_state = sbl_pkg::SBL_RUN;
      sbl_pkg::SBL_RUN: nxt_state = sbl_pkg::SBL_RUN;
      default: nxt_state = sbl_pkg::SBL_IDLE;
    endcase
  end

  // mode entry and exit; pin caught on first enabled edge after release
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_ff <= 1'b0;
      sampled_ff <= 1'b0;
    end else if (ce_in) begin
      if (soft_rst_in) mode_ff <= 1'b0;
      else if (!sampled_ff) begin
        sampled_ff <= 1'b1;
        mode_ff <= !boot_select_pin_in;
      end
    end
  end

  // state register; software reset returns to idle
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) state_ff <= sbl_pkg::SBL_IDLE;
    else if (ce_in) state_ff <= soft_rst_in ? sbl_pkg::SBL_IDLE : nxt_state;
  end

  // zero-byte timer, counts every 4th clock for 9/4 f/baud over 9 low bits
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meas_ff <= 16'h0000;
      pre_ff <= 2'h0;
    end else if (ce_in && state_ff == sbl_pkg::SBL_MEASURE) begin
      pre_ff <= pre_ff + 2'h1;
      // saturate: an overflowing host rate cannot be set up anyway
      if (pre_ff == 2'(sbl_pkg::MEAS_PRESCALE - 1) && meas_ff != 16'hffff)
        meas_ff <= meas_ff + 16'h0001;
    end
  end

  // reload = (count - 36) / 72 by repeated subtraction
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      quot_ff <= 16'h0000;
      rem_ff <= 16'h0000;
      reload_ff <= 16'h0000;
    end else if (ce_in) begin
      if (state_ff == sbl_pkg::SBL_MEASURE && line_hi) begin
        quot_ff <= 16'h0000;
        rem_ff <= (meas_ff > sbl_pkg::MEAS_OFFSET) ? meas_ff - sbl_pkg::MEAS_OFFSET : 16'h0000;
      end else if (state_ff == sbl_pkg::SBL_DIVIDE) begin
        if (div_more) begin
          rem_ff <= rem_ff - sbl_pkg::MEAS_DIVISOR;
          quot_ff <= quot_ff + 16'h0001;
        end else reload_ff <= quot_ff;
      end
    end
  end

  // presets on entry; transmit pin turns output once the rate is set
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctx_ff <= 16'h0000;
      stk_ff <= 16'h0000;
      sun_ff <= 16'h0000;
      sov_ff <= 16'h0000;
      scon_ff <= 16'h0000;
      sys_ff <= 16'h0000;
      tdir_ff <= 1'b0;
    end else if (ce_in) begin
      if (state_ff == sbl_pkg::SBL_IDLE && mode_ff) begin
        ctx_ff <= sbl_pkg::CTX_PTR_PRESET;
        stk_ff <= sbl_pkg::STACK_PTR_PRESET;
        sun_ff <= sbl_pkg::STACK_UNDER_PRESET;
        scon_ff <= sbl_pkg::SCON_PRESET;
        sys_ff <= sbl_pkg::SYSCFG_PRESET;
        sov_ff <= sbl_pkg::STACK_OVER_PRESET;
      end
      if (state_ff == sbl_pkg::SBL_SEND_ID) tdir_ff <= 1'b1;
      if (!mode_ff) tdir_ff <= 1'b0;
    end
  end

  // id transmit kick, ram writes, byte count and jump pulse
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_go_ff <= 1'b0;
      we_ff <= 1'b0;
      waddr_ff <= 24'h000000;
      wdata_ff <= 8'h00;
      cnt_ff <= 6'h00;
      jump_ff <= 1'b0;
    end else if (ce_in) begin
      tx_go_ff <= (state_ff == sbl_pkg::SBL_SEND_ID);
      we_ff <= 1'b0;
      jump_ff <= (state_ff == sbl_pkg::SBL_JUMP);
      if (state_ff == sbl_pkg::SBL_WAIT_ID) cnt_ff <= 6'h00;
      else if (state_ff == sbl_pkg::SBL_LOAD && rx_valid) begin
        we_ff <= 1'b1;
        waddr_ff <= sbl_pkg::LOAD_FIRST + 24'(cnt_ff);
        wdata_ff <= rx_data;
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  // flash window decode, follows segment mapping
  wire [23:0] win_lo = flash_seg1_in ? sbl_pkg::FLASH_BASE_SEG1 : sbl_pkg::FLASH_BASE_SEG0;
  wire [23:0] win_hi = flash_seg1_in ? sbl_pkg::FLASH_TOP_SEG1 : sbl_pkg::FLASH_TOP_SEG0;
  wire in_win = (fetch_addr_in >= win_lo) && (fetch_addr_in <= win_hi);
  // code fetches never reach flash while loading; data reads still do
  assign boot_rom_sel_out = mode_ff && in_win && fetch_is_code_in;
  assign user_flash_sel_out = in_win && !(mode_ff && fetch_is_code_in);
  // the external-access pin only counts outside loader mode
  assign use_external_access_out = !mode_ff && external_access_pin_in;

  // outputs
  assign boot_loader_mode_out = mode_ff;
  assign watchdog_disable_out = mode_ff;
  assign serial_transmit_line_out = tdir_ff ? txd_ch : 1'b1;
  assign transmit_pin_direction_out = tdir_ff;
  assign context_pointer_out = ctx_ff;
  assign stack_pointer_out = stk_ff;
  assign stack_underflow_limit_out = sun_ff;
  assign stack_overflow_limit_out = sov_ff;
  assign serial_control_reg_out = scon_ff;
  assign system_config_reg_out = sys_ff;
  assign baud_reload_value_out = reload_ff;
  assign ram_we_out = we_ff;
  assign ram_addr_out = waddr_ff;
  assign ram_wdata_out = wdata_ff;
  assign jump_out = jump_ff;
  assign jump_addr_out = mode_ff ? sbl_pkg::LOAD_FIRST : sbl_pkg::RESET_VECTOR;
endmodule
`default_nettype wire

// *** src/sbl_pkg.sv ***
// package for the serial bootstrap loader: constants, states, timing
`default_nettype none
package sbl_pkg;
  // preset values loaded when loader mode is entered
  localparam logic [15:0] CTX_PTR_PRESET = 16'hfa00;
  localparam logic [15:0] STACK_PTR_PRESET = 16'hfa40;
  localparam logic [15:0] STACK_UNDER_PRESET = 16'hfa40;
  localparam logic [15:0] STACK_OVER_PRESET = 16'hfa0c;
  localparam logic [15:0] SCON_PRESET = 16'h8011;
  localparam logic [15:0] SYSCFG_PRESET = 16'h0e00;
  // load area in internal ram
  localparam logic [23:0] LOAD_FIRST = 24'h00fa40;
  localparam logic [23:0] LOAD_LAST = 24'h00fa5f;
  localparam int LOAD_BYTES = 32;
  // flash window in segment 0, or segment 1 when remapped
  localparam logic [23:0] FLASH_BASE_SEG0 = 24'h000000;
  localparam logic [23:0] FLASH_BASE_SEG1 = 24'h010000;
  localparam logic [23:0] FLASH_TOP_SEG0 = 24'h007fff;
  localparam logic [23:0] FLASH_TOP_SEG1 = 24'h017fff;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  // baud measurement: reload = (count - 36) / 72, rate = f / (32 (reload + 1))
  localparam logic [15:0] MEAS_OFFSET = 16'h0024;
  localparam logic [15:0] MEAS_DIVISOR = 16'h0048;
  localparam int BIT_TICKS = 32;
  // timer prescale: measurement timer counts once every 4 clocks, a quarter of the bit length per bit
  localparam int MEAS_PRESCALE = 4;
  // character framing
  localparam int DATA_BITS = 8;
  // loader sequencer states
  typedef enum logic [3:0] {
    SBL_IDLE = 4'h0,
    SBL_WAIT_START = 4'h1,
    SBL_MEASURE = 4'h2,
    SBL_DIVIDE = 4'h3,
    SBL_SEND_ID = 4'h4,
    SBL_WAIT_ID = 4'h5,
    SBL_LOAD = 4'h6,
    SBL_JUMP = 4'h7,
    SBL_RUN = 4'h8
  } sbl_state_t;
endpackage
`default_nettype wire

// *** src/sbl_uart.sv ***
// serial channel used by the loader: transmit and receive, 8n1, fixed 32 ticks a bit
`default_nettype none
module sbl_uart #(
  parameter int BIT_TICKS = 32
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [15:0] reload_in, // baud reload, rate = f / (32 (reload + 1))
  input wire logic rx_en_in, // receiver enabled
  input wire logic rxd_in, // receive line, idle high
  input wire logic tx_go_in, // one-cycle start of a transmit
  input wire logic [7:0] tx_data_in,
  output logic tx_busy_out,
  output logic txd_out,
  output logic rx_valid_out, // one-cycle pulse per received byte
  output logic [7:0] rx_data_out
);
  // prescaler: one tick every reload+1 clocks
  logic [15:0] pre_ff;
  wire tick = (pre_ff == reload_in);
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) pre_ff <= 16'h0000;
    else if (ce_in) pre_ff <= tick ? 16'h0000 : pre_ff + 16'h0001;
  end

  // transmitter: 10-bit frame shifted out lsb first, start bit low
  logic [9:0] tsh_ff;
  logic [3:0] tcnt_ff;
  logic [4:0] ttick_ff;
  assign tx_busy_out = (tcnt_ff != 4'h0);
  assign txd_out = tx_busy_out ? tsh_ff[0] : 1'b1;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tsh_ff <= 10'h3ff;
      tcnt_ff <= 4'h0;
      ttick_ff <= 5'h00;
    end else if (ce_in) begin
      if (tx_go_in && !tx_busy_out) begin
        // load stop, data, start
        tsh_ff <= {1'b1, tx_data_in, 1'b0};
        tcnt_ff <= 4'ha;
        ttick_ff <= 5'h00;
      end else if (tx_busy_out && tick) begin
        ttick_ff <= ttick_ff + 5'h01;
        if (ttick_ff == 5'(BIT_TICKS - 1)) begin
          // bit time over: next bit
          tsh_ff <= {1'b1, tsh_ff[9:1]};
          tcnt_ff <= tcnt_ff - 4'h1;
        end
      end
    end
  end

  // receiver: centre-sampled, start bit checked at mid-bit
  logic [7:0] rsh_ff;
  logic [3:0] rcnt_ff;
  logic [4:0] rtick_ff;
  logic rvalid_ff;
  logic [7:0] rdata_ff;
  assign rx_valid_out = rvalid_ff;
  assign rx_data_out = rdata_ff;
  wire rx_mid = tick && (rtick_ff == 5'(BIT_TICKS / 2 - 1));
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsh_ff <= 8'h00;
      rcnt_ff <= 4'h0;
      rtick_ff <= 5'h00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (ce_in) begin
      rvalid_ff <= 1'b0;
      if (!rx_en_in) begin
        rcnt_ff <= 4'h0;
      end else if (rcnt_ff == 4'h0) begin
        // hunt for a falling start edge
        if (!rxd_in) begin
          rcnt_ff <= 4'h1;
          rtick_ff <= 5'h00;
        end
      end else if (tick) begin
        rtick_ff <= rtick_ff + 5'h01;
        if (rx_mid) begin
          if (rcnt_ff == 4'h1 && rxd_in) rcnt_ff <= 4'h0; // false start
          else if (rcnt_ff == 4'ha) begin
            // stop bit reached: deliver byte, ignore framing error
            rcnt_ff <= 4'h0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rsh_ff;
          end else begin
            if (rcnt_ff != 4'h1) rsh_ff <= {rxd_in, rsh_ff[7:1]};
            rcnt_ff <= rcnt_ff + 4'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire
